// >>> core/pml_pkg.sv
// shared constants for the slow parallel link, phy side
package pml_pkg;

   // reference clock and nominal link clock rates, in Hz
   localparam int REF_CLK_HZ   = 20_000_000;
   localparam int LINK_HZ_1000 = 62_500_000;
   localparam int LINK_HZ_100  = 50_000_000;
   localparam int LINK_HZ_10   = 5_000_000;

   // half periods in reference cycles; floored, never below one cycle
   localparam int HALF_1000_RAW = REF_CLK_HZ / (2 * LINK_HZ_1000);
   localparam int HALF_100_RAW  = REF_CLK_HZ / (2 * LINK_HZ_100);
   localparam int HALF_10_RAW   = REF_CLK_HZ / (2 * LINK_HZ_10);
   localparam logic [7:0] HALF_1000 =
      8'((HALF_1000_RAW < 1) ? 1 : HALF_1000_RAW);
   localparam logic [7:0] HALF_100  =
      8'((HALF_100_RAW < 1) ? 1 : HALF_100_RAW);
   localparam logic [7:0] HALF_10   =
      8'((HALF_10_RAW < 1) ? 1 : HALF_10_RAW);

   // link speed codes on link_speed_i
   localparam logic [1:0] SPD_10     = 2'h0;
   localparam logic [1:0] SPD_100    = 2'h1;
   localparam logic [1:0] SPD_1000   = 2'h2;
   localparam logic [1:0] SPD_NOLINK = 2'h3;

   // word framing: groups of three lines per word
   localparam int LINE_W      = 3;
   localparam int WORD_GROUPS = 4;
   localparam int WORD_W      = LINE_W * WORD_GROUPS;

   // consecutive asserted samples at which a reset is declared, or after which a sync is declared
   localparam logic [1:0] RS_RESET_CNT = 2'h2;
   localparam logic [1:0] RS_SYNC_CNT  = 2'h1;

   typedef enum logic [2:0] {
      ST_RUN   = 3'h1,
      ST_PDOWN = 3'h2,
      ST_OFF   = 3'h4
   } pml_state_t;

endpackage : pml_pkg

// >>> core/pml_buf2.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module pml_buf2 #(
   parameter int W = 12
) (
   // clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         resetn_i,
   // filling side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // draining side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o,
   // flush
   input  wire logic         flush_i
);

   logic [W-1:0] mem_r [2];
   logic         wr_ptr_r;
   logic         rd_ptr_r;
   logic [1:0]   count_r;
   logic         push;
   logic         pop;

   assign in_ready_o  = (count_r != 2'h2);
   assign out_valid_o = (count_r != 2'h0);
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
      end else if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'h0;
      end else if (flush_i) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push && !pop) begin
            count_r <= count_r + 2'h1;
         end else if (pop && !push) begin
            count_r <= count_r - 2'h1;
         end
      end
   end

endmodule : pml_buf2

// >>> core/pml_link_phy.sv
// phy end of the slow parallel link: clock, reset/sync, framing
`timescale 1ns/1ns

module pml_link_phy #(
   parameter logic [7:0] HALF_1000 = pml_pkg::HALF_1000,
   parameter logic [7:0] HALF_100  = pml_pkg::HALF_100,
   parameter logic [7:0] HALF_10   = pml_pkg::HALF_10,
   parameter int         WORD_W    = pml_pkg::WORD_W
) (
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              resetn_i,
   // link pins
   output logic                   link_clock_out_o,
   input  wire logic              reset_sync_in_i,
   input  wire logic [2:0]        mac_to_phy_lines_i,
   output logic [2:0]             phy_to_mac_lines_o,
   // straps and pins
   input  wire logic              port_disable_n_i,
   input  wire logic              test_mode_strap_i,
   // control from phy core
   input  wire logic [1:0]        link_speed_i,
   input  wire logic              power_down_i,
   // status to phy core
   output logic                   phy_reset_o,
   output logic                   sync_pulse_o,
   output logic                   power_down_o,
   output logic                   disabled_o,
   output logic                   test_mode_o,
   output logic                   rx_overrun_o,
   // words received from the mac
   output logic                   rx_valid_o,
   input  wire logic              rx_ready_i,
   output logic [WORD_W-1:0]      rx_word_o,
   // words sent to the mac
   input  wire logic              tx_valid_i,
   output logic                   tx_ready_o,
   input  wire logic [WORD_W-1:0] tx_word_i
);

   localparam int GROUPS = WORD_W / pml_pkg::LINE_W;
   localparam logic [7:0] WAKE_CYC = 8'(2 * int'(HALF_10));

   pml_pkg::pml_state_t state_r;
   pml_pkg::pml_state_t state_nxt;

   logic              rs_meta_r, rs_sync_r;
   logic [2:0]        txd_meta_r, txd_sync_r;
   logic              dis_meta_r, dis_sync_r;
   logic              strap_meta_r, strap_sync_r;
   logic [7:0]        half_cnt_r;
   logic [7:0]        half_sel;
   logic              lclk_r;
   logic              clk_run;
   logic              tick;
   logic              rise;
   logic              fall;
   logic [1:0]        rs_cnt_r;
   logic              sync_det;
   logic [7:0]        wake_cnt_r;
   logic [7:0]        rx_grp_r;
   logic [7:0]        tx_grp_r;
   logic [WORD_W-1:0] rx_shift_r;
   logic [WORD_W-1:0] tx_shift_r;
   logic [WORD_W-1:0] rx_full;
   logic              rx_push;
   logic              rx_in_ready;
   logic              tx_buf_valid;
   logic [WORD_W-1:0] tx_buf_data;
   logic              tx_pop;
   logic              flush;

   // every pin passes two flops first
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rs_meta_r    <= 1'b0;
         rs_sync_r    <= 1'b0;
         txd_meta_r   <= 3'h0;
         txd_sync_r   <= 3'h0;
         dis_meta_r   <= 1'b1;
         dis_sync_r   <= 1'b1;
         strap_meta_r <= 1'b0;
         strap_sync_r <= 1'b0;
      end else begin
         rs_meta_r    <= reset_sync_in_i;
         rs_sync_r    <= rs_meta_r;
         txd_meta_r   <= mac_to_phy_lines_i;
         txd_sync_r   <= txd_meta_r;
         dis_meta_r   <= port_disable_n_i;
         dis_sync_r   <= dis_meta_r;
         strap_meta_r <= test_mode_strap_i;
         strap_sync_r <= strap_meta_r;
      end
   end

   // power state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pml_pkg::ST_RUN: begin
            if (power_down_i) begin
               state_nxt = pml_pkg::ST_PDOWN;
            end
         end
         pml_pkg::ST_PDOWN: begin
            if (wake_cnt_r > WAKE_CYC) begin
               state_nxt = pml_pkg::ST_RUN;
            end
         end
         pml_pkg::ST_OFF: begin
            state_nxt = pml_pkg::ST_RUN;
         end
         default: begin
            state_nxt = pml_pkg::ST_RUN;
         end
      endcase
      if (!dis_sync_r) begin
         state_nxt = pml_pkg::ST_OFF;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= pml_pkg::ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // link clock is stopped, so wake is timed on the reference clock
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_cnt_r <= 8'h00;
      end else if (state_r == pml_pkg::ST_PDOWN && rs_sync_r) begin
         if (wake_cnt_r != 8'hff) begin
            wake_cnt_r <= wake_cnt_r + 8'h01;
         end
      end else begin
         wake_cnt_r <= 8'h00;
      end
   end

   // link clock divider
   always_comb begin
      case (link_speed_i)
         pml_pkg::SPD_1000: half_sel = HALF_1000;
         pml_pkg::SPD_100:  half_sel = HALF_100;
         default:           half_sel = HALF_10;
      endcase
   end

   assign clk_run = (state_r == pml_pkg::ST_RUN);
   assign tick    = clk_run && (half_cnt_r + 8'h01 >= half_sel);
   assign rise    = tick && !lclk_r;
   assign fall    = tick && lclk_r;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         half_cnt_r <= 8'h00;
         lclk_r     <= 1'b0;
      end else if (!clk_run) begin
         half_cnt_r <= 8'h00;
         lclk_r     <= 1'b0;
      end else if (tick) begin
         half_cnt_r <= 8'h00;
         lclk_r     <= ~lclk_r;
      end else begin
         half_cnt_r <= half_cnt_r + 8'h01;
      end
   end

   assign link_clock_out_o = lclk_r;

   // reset/sync classification; the mac keeps its own 1 ms hold
   assign sync_det = rise && !rs_sync_r && (rs_cnt_r == pml_pkg::RS_SYNC_CNT);

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rs_cnt_r     <= 2'h0;
         phy_reset_o  <= 1'b0;
         sync_pulse_o <= 1'b0;
      end else begin
         sync_pulse_o <= sync_det;
         if (!clk_run) begin
            rs_cnt_r    <= 2'h0;
            phy_reset_o <= 1'b0;
         end else if (rise) begin
            if (rs_sync_r) begin
               if (rs_cnt_r != 2'h3) begin
                  rs_cnt_r <= rs_cnt_r + 2'h1;
               end
               if (rs_cnt_r + 2'h1 >= pml_pkg::RS_RESET_CNT) begin
                  phy_reset_o <= 1'b1;
               end
            end else begin
               rs_cnt_r    <= 2'h0;
               phy_reset_o <= 1'b0;
            end
         end
      end
   end

   // receive framing; mac lines are stable across our rising edge
   assign rx_full = {rx_shift_r[WORD_W-4:0], txd_sync_r};
   // a sync rise only starts a word, so it never pushes or overruns
   assign rx_push = rise && !phy_reset_o && !rs_sync_r && !sync_det &&
                    (rx_grp_r == 8'(GROUPS - 1));
   assign flush   = phy_reset_o || !clk_run;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_grp_r   <= 8'h00;
         rx_shift_r <= '0;
      end else if (flush) begin
         rx_grp_r   <= 8'h00;
         rx_shift_r <= '0;
      end else if (rise && !rs_sync_r) begin
         rx_shift_r <= rx_full;
         if (sync_det) begin
            rx_grp_r <= 8'h01;
         end else if (rx_grp_r == 8'(GROUPS - 1)) begin
            rx_grp_r <= 8'h00;
         end else begin
            rx_grp_r <= rx_grp_r + 8'h01;
         end
      end
   end

   // no stall reaches the mac, so a full buffer drops the word
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_overrun_o <= 1'b0;
      end else begin
         rx_overrun_o <= rx_push && !rx_in_ready;
      end
   end

   pml_buf2 #(.W(WORD_W)) u_rx_buf (
      .ref_clk_i   (ref_clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (rx_push),
      .in_ready_o  (rx_in_ready),
      .in_data_i   (rx_full),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  (rx_word_o),
      .flush_i     (1'b0)
   );

   // transmit framing, driven on falling edges; idle word is all zero
   assign tx_pop = fall && !phy_reset_o && (tx_grp_r == 8'h00) &&
                   tx_buf_valid;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_grp_r           <= 8'h00;
         tx_shift_r         <= '0;
         phy_to_mac_lines_o <= 3'h0;
      end else if (flush) begin
         tx_grp_r           <= 8'h00;
         tx_shift_r         <= '0;
         phy_to_mac_lines_o <= 3'h0;
      end else if (sync_det) begin
         tx_grp_r <= 8'h00;
      end else if (fall) begin
         if (tx_grp_r == 8'h00) begin
            phy_to_mac_lines_o <= tx_buf_valid ?
               tx_buf_data[WORD_W-1 -: 3] : 3'h0;
            tx_shift_r <= tx_buf_valid ?
               {tx_buf_data[WORD_W-4:0], 3'h0} : '0;
         end else begin
            phy_to_mac_lines_o <= tx_shift_r[WORD_W-1 -: 3];
            tx_shift_r         <= {tx_shift_r[WORD_W-4:0], 3'h0};
         end
         tx_grp_r <= (tx_grp_r == 8'(GROUPS - 1)) ? 8'h00 :
                     tx_grp_r + 8'h01;
      end
   end

   pml_buf2 #(.W(WORD_W)) u_tx_buf (
      .ref_clk_i   (ref_clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_word_i),
      .out_valid_o (tx_buf_valid),
      .out_ready_i (tx_pop),
      .out_data_o  (tx_buf_data),
      .flush_i     (1'b0)
   );

   // status outputs
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         power_down_o <= 1'b0;
         disabled_o   <= 1'b0;
         test_mode_o  <= 1'b0;
      end else begin
         power_down_o <= (state_r == pml_pkg::ST_PDOWN);
         disabled_o   <= (state_r == pml_pkg::ST_OFF);
         test_mode_o  <= strap_sync_r;
      end
   end

endmodule : pml_link_phy

// >>> bench/pml_mac_model.sv
// behavioural mac end of the slow parallel link
`timescale 1ns/1ns
module pml_mac_model (
   // link pins
   input  wire logic       link_clock_out_i,
   input  wire logic [2:0] phy_to_mac_lines_i,
   output logic            reset_sync_in_o,
   output logic [2:0]      mac_to_phy_lines_o,
   // words seen from the phy
   output logic [11:0]     got_word_o,
   output logic            got_stb_o
);
   int         grp = 0;
   logic [8:0] sh  = 9'h000;
   initial begin
      reset_sync_in_o    = 1'b0;
      mac_to_phy_lines_o = 3'h0;
      got_word_o         = 12'h000;
      got_stb_o          = 1'b0;
   end
   // one link clock high marks a word boundary
   task automatic sync_pulse();
      @(posedge link_clock_out_i);
      reset_sync_in_o <= 1'b1;
      @(posedge link_clock_out_i);
      reset_sync_in_o <= 1'b0;
   endtask : sync_pulse
   // msb group first, lines change just after a rise; idle is zero
   // more: next word follows at once, its first group replaces idle
   task automatic send_word(input logic [11:0] w, bit more);
      for (int i = 3; i >= 0; i--) begin
         mac_to_phy_lines_o <= w[i*3 +: 3];
         @(posedge link_clock_out_i);
      end
      if (!more) mac_to_phy_lines_o <= 3'h0;
   endtask : send_word
   // asynchronous long assertion: reset and wake-up
   task automatic hold_reset(input int ns);
      reset_sync_in_o <= 1'b1;
      #(ns);
      reset_sync_in_o <= 1'b0;
   endtask : hold_reset
   // phy groups framed from our own sync; zero words are idle
   always @(posedge link_clock_out_i) begin
      sh        <= {sh[5:0], phy_to_mac_lines_i};
      grp       <= reset_sync_in_o ? -1 : (grp == 3 ? 0 : grp + 1);
      if (grp == 3 && {sh, phy_to_mac_lines_i} != 12'h000) begin
         got_word_o <= {sh, phy_to_mac_lines_i};
      end
      got_stb_o <= (grp == 3) && ({sh, phy_to_mac_lines_i} != 12'h000);
   end
endmodule : pml_mac_model

// >>> bench/pml_link_phy_monitor.sv
// checker of the phy link end, bound to its ports
`timescale 1ns/1ns
module pml_link_phy_monitor #(
   parameter int WORD_W = 12
) (
   input wire logic              ref_clk_i,
   input wire logic              resetn_i,
   input wire logic              link_clock_out_o,
   input wire logic              reset_sync_in_i,
   input wire logic [2:0]        phy_to_mac_lines_o,
   input wire logic              port_disable_n_i,
   input wire logic              test_mode_strap_i,
   input wire logic [1:0]        link_speed_i,
   input wire logic              phy_reset_o,
   input wire logic              sync_pulse_o,
   input wire logic              power_down_o,
   input wire logic              disabled_o,
   input wire logic              test_mode_o,
   input wire logic              rx_overrun_o,
   input wire logic              rx_valid_o,
   input wire logic              rx_ready_i,
   input wire logic [WORD_W-1:0] rx_word_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // checks assume half periods of 4, 2 and 1 reference cycles
   sequence long_rs_s;
      reset_sync_in_i [*8] ##1 reset_sync_in_i [*5];
   endsequence
   sequence fast_s;
      (link_speed_i == pml_pkg::SPD_1000) [*3];
   endsequence
   sequence mid_s;
      (link_speed_i == pml_pkg::SPD_100) [*3];
   endsequence
   clk_stop_a: assert property ((power_down_o || disabled_o) [*2]
      |-> !link_clock_out_o) else $error("link clock runs while stopped");
   clk_slow_a: assert property (link_clock_out_o [*4]
      |=> !link_clock_out_o) else $error("link clock high too long");
   clk_fast_a: assert property (fast_s ##0 $rose(link_clock_out_o)
      |=> !link_clock_out_o) else $error("gigabit half period wrong");
   clk_mid_a: assert property (mid_s ##0 $rose(link_clock_out_o)
      |=> link_clock_out_o ##1 !link_clock_out_o)
      else $error("100M half period wrong");
   sync_once_a: assert property (sync_pulse_o
      |-> !phy_reset_o ##1 !sync_pulse_o) else $error("sync pulse wrong");
   wake_up_a: assert property (power_down_o ##0 long_rs_s
      |-> ##[0:6] !power_down_o) else $error("no wake from power-down");
   rx_hold_a: assert property (rx_valid_o && !rx_ready_i
      && !phy_reset_o && !disabled_o |=> rx_valid_o && $stable(rx_word_o))
      else $error("rx word not held");
   overrun_pulse_a: assert property (rx_overrun_o
      |-> rx_valid_o ##1 !rx_overrun_o) else $error("overrun pulse wrong");
   tx_edge_a: assert property ($changed(phy_to_mac_lines_o)
      && !phy_reset_o && !power_down_o && !disabled_o
      |-> $fell(link_clock_out_o)) else $error("tx lines off the fall");
   disable_in_a: assert property ($fell(port_disable_n_i)
      |-> ##[1:4] disabled_o) else $error("disable not taken");
   test_on_a: assert property ($rose(test_mode_strap_i)
      |-> ##[1:4] test_mode_o) else $error("test mode not entered");
endmodule : pml_link_phy_monitor
bind pml_link_phy pml_link_phy_monitor #(.WORD_W(WORD_W)) u_mon (.*);

// >>> bench/test_pml_link_phy.sv
// self-checking bench for the phy end of the slow parallel link
`timescale 1ns/1ns
module test_pml_link_phy;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i  = 1'b0;
   logic        lclk, rs, pdis_n = 1'b1, strap = 1'b0, pdown = 1'b0;
   logic [2:0]  m2p, p2m;
   logic [1:0]  speed = pml_pkg::SPD_10;
   logic        phy_rst, sync_p, pd_o, dis_o, tm_o, ovr, rx_v, tx_r, got_s;
   logic        rx_r = 1'b0, tx_v = 1'b0, stall = 1'b0;
   logic [11:0] rx_w, got_w, tx_w = 12'h000;
   logic [11:0] per[4] = '{12'h008, 12'h004, 12'h002, 12'h008};
   logic [11:0] rx_q[$], tx_q[$];
   logic [3:0]  seen = 4'h0;
   int          seed = 50, n_checks = 0, n_mismatch = 0, cyc = 0;
   time         t0;
   always #25 ref_clk_i = ~ref_clk_i;
   pml_link_phy #(.HALF_1000(8'h01), .HALF_100(8'h02), .HALF_10(8'h04))
   u_pml_link_phy (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .link_clock_out_o(lclk), .reset_sync_in_i(rs),
      .mac_to_phy_lines_i(m2p), .phy_to_mac_lines_o(p2m),
      .port_disable_n_i(pdis_n), .test_mode_strap_i(strap),
      .link_speed_i(speed), .power_down_i(pdown), .phy_reset_o(phy_rst),
      .sync_pulse_o(sync_p), .power_down_o(pd_o), .disabled_o(dis_o),
      .test_mode_o(tm_o), .rx_overrun_o(ovr), .rx_valid_o(rx_v),
      .rx_ready_i(rx_r), .rx_word_o(rx_w), .tx_valid_i(tx_v),
      .tx_ready_o(tx_r), .tx_word_i(tx_w));
   pml_mac_model u_pml_mac_model (.link_clock_out_i(lclk),
      .phy_to_mac_lines_i(p2m), .reset_sync_in_o(rs),
      .mac_to_phy_lines_o(m2p), .got_word_o(got_w), .got_stb_o(got_s));
   task automatic chk(input string nm, input logic [11:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic wait_ref(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : wait_ref
   // more: another word follows at once, so the lines are not idled
   task automatic rx_send(input logic [11:0] w, input bit keep, more);
      if (keep) rx_q.push_back(w);
      u_pml_mac_model.send_word(w, more);
   endtask : rx_send
   // valid held until ready is sampled high
   task automatic tx_send(input logic [11:0] w);
      @(posedge ref_clk_i);
      tx_v <= 1'b1;
      tx_w <= w;
      tx_q.push_back(w);
      do @(posedge ref_clk_i); while (tx_r !== 1'b1);
      tx_v <= 1'b0;
   endtask : tx_send
   // consumer stalls a quarter of the time, or always when told
   always @(posedge ref_clk_i) begin
      rx_r <= !stall && ($random(seed) % 4 != 0);
      seen <= seen | {ovr === 1'b1, tx_r === 1'b0, sync_p === 1'b1,
                      phy_rst === 1'b1};
      cyc  <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         test_done();
      end
   end
   always @(posedge ref_clk_i)
      if (rx_v === 1'b1 && rx_r === 1'b1 && rx_w !== 12'h000)
         chk("rx word", rx_q.pop_front(), rx_w);
   // mid-period, where the model's word and strobe have settled
   always @(negedge lclk)
      if (got_s === 1'b1)
         chk("tx word", tx_q.pop_front(), got_w);
   initial begin
      wait_ref(16);
      resetn_i <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         speed <= 2'(s);
         repeat (2) @(posedge lclk);
         t0 = $time;
         @(posedge lclk);
         chk("link period", per[s], 12'(($time - t0) / 50));
      end
      speed <= pml_pkg::SPD_10;
      $display("test link rates done");
      u_pml_mac_model.sync_pulse();
      fork
         for (int i = 0; i < 6; i++)
            rx_send(12'($random(seed)) | 12'h800, 1, i < 5);
         for (int i = 0; i < 6; i++) tx_send(12'($random(seed)) | 12'h400);
      join
      u_pml_mac_model.sync_pulse();
      stall <= 1'b1;
      for (int i = 0; i < 3; i++)
         rx_send(12'($random(seed)) | 12'h100, i < 2, i < 2);
      stall <= 1'b0;
      for (int k = 0; k < 2000 && rx_q.size() + tx_q.size() > 0; k++)
         @(posedge ref_clk_i);
      chk("words left", 12'h000, 12'(rx_q.size() + tx_q.size()));
      chk("sync, full, overrun", 12'h007, seen[3:1]);
      $display("test word traffic done");
      pdown <= 1'b1;
      wait_ref(1);
      pdown <= 1'b0;
      wait_ref(20);
      chk("power down", 12'h001, pd_o);
      chk("stopped clock", 12'h000, lclk);
      fork
         u_pml_mac_model.hold_reset(1000000);
         begin
            wait_ref(40);
            chk("woken", 12'h000, pd_o);
            chk("phy reset", 12'h001, phy_rst);
         end
      join
      wait_ref(40);
      chk("phy reset end", 12'h000, phy_rst);
      $display("test power and reset done");
      strap <= 1'b1;
      wait_ref(6);
      chk("test mode", 12'h001, tm_o);
      strap <= 1'b0;
      pdis_n <= 1'b0;
      wait_ref(6);
      chk("test mode off", 12'h000, tm_o);
      chk("disabled", 12'h001, dis_o);
      chk("disabled clock", 12'h000, lclk);
      pdis_n <= 1'b1;
      $display("test straps done");
      test_done();
   end
endmodule : test_pml_link_phy
